/* File: switch_global_control_regs.sv */
// Overview of operation
// - Bit 7 enables 802.1Q VLAN, reset 0
// - Bits 3-2 pick egress priority ratio
// - Bit 0 selects AND versus OR sniffing
// - MII half duplex bit, strap default
// - MII flow control bit, strap default
// - MII 10 Mbps bit, strap default
// - Bit 3 enables null VID replacement
// - Eleven-bit storm threshold across two registers
// - Storm period 500 ms at 10 Mbps
// - Storm period 67 ms at 100 Mbps
// - Threshold resets to 0x063, about one percent
`default_nettype none
module switch_global_control_regs #(
  parameter int STORM_PERIOD_10M_CYC = glob_cfg_pkg::STORM_PERIOD_10M_CYC,
  parameter int STORM_PERIOD_100M_CYC = glob_cfg_pkg::STORM_PERIOD_100M_CYC
) (
  input wire logic REF_CLK, // Core clock, 20 MHz
  input wire logic RST_B, // Async reset, active low
  input wire logic [7:0] REG_ADDR, // Register address
  input wire logic REG_WR, // Write strobe
  input wire logic [7:0] REG_WDATA, // Write data
  input wire logic REG_RD, // Read strobe
  output logic [7:0] REG_RDATA, // Read data
  output logic REG_RVALID, // Read data valid pulse
  input wire logic MII_DUPLEX_STRAP_PIN, // Duplex strap
  input wire logic MII_FLOW_CTRL_STRAP_PIN, // Flow control strap
  input wire logic MII_SPEED_STRAP_PIN, // Speed strap
  output logic CFG_READY, // Straps loaded, writes accepted
  output logic VLAN_EN, // 802.1Q VLAN on
  output logic [1:0] PRIO_SCHEME, // Priority scheme field
  output logic [3:0] HIGH_PER_LOW, // High frames per low frame
  output logic SNIFF_AND_MODE, // Source and destination must match
  output logic MII_HALF_DUPLEX, // MII half duplex
  output logic MII_FLOW_CTRL_EN, // MII flow control
  output logic MII_10M, // MII at 10 Mbps
  output logic NULL_VID_REPLACE, // Replace null VID
  output logic [10:0] STORM_THRESHOLD, // Storm block count
  output logic STORM_PERIOD_TICK // End of metering period
);
  localparam logic [23:0] PERIOD_10M_LAST = 24'(STORM_PERIOD_10M_CYC - 1);
  localparam logic [23:0] PERIOD_100M_LAST = 24'(STORM_PERIOD_100M_CYC - 1);

  glob_cfg_pkg::cfg_state_t s_q;
  glob_cfg_pkg::cfg_state_t s_d;
  logic dup_lvl;
  logic fc_lvl;
  logic spd_lvl;
  logic [23:0] period_last;

  strap_sync u_dup_sync (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .pin(MII_DUPLEX_STRAP_PIN),
    .level(dup_lvl)
  );
  strap_sync u_fc_sync (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .pin(MII_FLOW_CTRL_STRAP_PIN),
    .level(fc_lvl)
  );
  strap_sync u_spd_sync (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .pin(MII_SPEED_STRAP_PIN),
    .level(spd_lvl)
  );

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.tick = 1'b0;
    unique case (s_q.mode)
      glob_cfg_pkg::ST_WAIT: begin
        // Catch straps once the synchronisers have settled
        if (s_q.settle == glob_cfg_pkg::STRAP_SETTLE_CYC) begin
          s_d.ctl4[glob_cfg_pkg::MII_HALF_DUPLEX_BIT] = dup_lvl;
          s_d.ctl4[glob_cfg_pkg::MII_FLOW_CTRL_BIT] = fc_lvl;
          s_d.ctl4[glob_cfg_pkg::MII_10M_BIT] = spd_lvl;
          s_d.mode = glob_cfg_pkg::ST_RUN;
        end else begin
          s_d.settle = s_q.settle + 3'h1;
        end
      end
      glob_cfg_pkg::ST_RUN: begin
        // Full byte writes; reserved bits store too
        if (REG_WR) begin
          unique case (REG_ADDR)
            glob_cfg_pkg::VLAN_PRIORITY_SNIFF_CONTROL_OFS: begin
              s_d.ctl3 = REG_WDATA;
            end
            glob_cfg_pkg::MII_PORT_AND_STORM_HIGH_CONTROL_OFS: begin
              s_d.ctl4 = REG_WDATA;
            end
            glob_cfg_pkg::STORM_THRESHOLD_LOW_OFS: begin
              s_d.thr_low = REG_WDATA;
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        s_d.mode = glob_cfg_pkg::ST_WAIT;
        s_d.settle = 3'h0;
      end
    endcase

    if (REG_RD) begin
      s_d.rvalid = 1'b1;
      unique case (REG_ADDR)
        glob_cfg_pkg::VLAN_PRIORITY_SNIFF_CONTROL_OFS: s_d.rdata = s_q.ctl3;
        glob_cfg_pkg::MII_PORT_AND_STORM_HIGH_CONTROL_OFS: s_d.rdata = s_q.ctl4;
        glob_cfg_pkg::STORM_THRESHOLD_LOW_OFS: s_d.rdata = s_q.thr_low;
        default: s_d.rdata = glob_cfg_pkg::UNMAPPED_RDATA;
      endcase
    end

    // Ratio follows the field in the same cycle it lands
    unique case (s_d.ctl3[glob_cfg_pkg::PRIO_HI_BIT:glob_cfg_pkg::PRIO_LO_BIT])
      2'h0: s_d.ratio = glob_cfg_pkg::RATIO_HIGH_FIRST;
      2'h1: s_d.ratio = glob_cfg_pkg::RATIO_10_TO_1;
      2'h2: s_d.ratio = glob_cfg_pkg::RATIO_5_TO_1;
      2'h3: s_d.ratio = glob_cfg_pkg::RATIO_2_TO_1;
    endcase

    // Metering period by the MII speed; a shorter limit ends the period at once
    if (s_q.period_cnt >= period_last) begin
      s_d.period_cnt = 24'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.period_cnt = s_q.period_cnt + 24'h1;
    end
  end

  assign period_last = s_q.ctl4[glob_cfg_pkg::MII_10M_BIT] ? PERIOD_10M_LAST
                                                           : PERIOD_100M_LAST;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q.mode <= glob_cfg_pkg::ST_WAIT;
      s_q.settle <= 3'h0;
      s_q.ctl3 <= glob_cfg_pkg::VLAN_PRIORITY_SNIFF_CONTROL_RST;
      s_q.ctl4 <= glob_cfg_pkg::MII_PORT_AND_STORM_HIGH_CONTROL_RST;
      s_q.thr_low <= glob_cfg_pkg::STORM_THRESHOLD_LOW_RST;
      s_q.rdata <= glob_cfg_pkg::UNMAPPED_RDATA;
      s_q.rvalid <= 1'b0;
      s_q.ratio <= glob_cfg_pkg::RATIO_HIGH_FIRST;
      s_q.period_cnt <= 24'h0;
      s_q.tick <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA = s_q.rdata;
  assign REG_RVALID = s_q.rvalid;
  assign CFG_READY = (s_q.mode == glob_cfg_pkg::ST_RUN);
  assign VLAN_EN = s_q.ctl3[glob_cfg_pkg::VLAN_EN_BIT];
  assign PRIO_SCHEME = s_q.ctl3[glob_cfg_pkg::PRIO_HI_BIT:glob_cfg_pkg::PRIO_LO_BIT];
  assign HIGH_PER_LOW = s_q.ratio;
  assign SNIFF_AND_MODE = s_q.ctl3[glob_cfg_pkg::SNIFF_AND_BIT];
  assign MII_HALF_DUPLEX = s_q.ctl4[glob_cfg_pkg::MII_HALF_DUPLEX_BIT];
  assign MII_FLOW_CTRL_EN = s_q.ctl4[glob_cfg_pkg::MII_FLOW_CTRL_BIT];
  assign MII_10M = s_q.ctl4[glob_cfg_pkg::MII_10M_BIT];
  assign NULL_VID_REPLACE = s_q.ctl4[glob_cfg_pkg::NULL_VID_BIT];
  assign STORM_THRESHOLD = {s_q.ctl4[glob_cfg_pkg::STORM_HIGH_MSB:0], s_q.thr_low};
  assign STORM_PERIOD_TICK = s_q.tick;

  logic wr3;
  logic wr4;
  logic wr5;
  assign wr3 = CFG_READY && REG_WR &&
               (REG_ADDR == glob_cfg_pkg::VLAN_PRIORITY_SNIFF_CONTROL_OFS);
  assign wr4 = CFG_READY && REG_WR &&
               (REG_ADDR == glob_cfg_pkg::MII_PORT_AND_STORM_HIGH_CONTROL_OFS);
  assign wr5 = CFG_READY && REG_WR &&
               (REG_ADDR == glob_cfg_pkg::STORM_THRESHOLD_LOW_OFS);

  a_vlan_enable_write: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    wr3 |=> VLAN_EN == $past(REG_WDATA[7]))
    else $error("VLAN enable did not follow write");

  a_prio_ratio_map: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    HIGH_PER_LOW == ((PRIO_SCHEME == 2'h0) ? 4'h0 : (PRIO_SCHEME == 2'h1) ? 4'ha :
                     (PRIO_SCHEME == 2'h2) ? 4'h5 : 4'h2))
    else $error("Priority ratio does not match scheme");

  a_sniff_mode_write: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    wr3 |=> SNIFF_AND_MODE == $past(REG_WDATA[0]) && PRIO_SCHEME == $past(REG_WDATA[3:2]))
    else $error("Sniff or priority field did not follow write");

  a_strap_capture: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    $rose(CFG_READY) |-> MII_HALF_DUPLEX == $past(dup_lvl) &&
                         MII_FLOW_CTRL_EN == $past(fc_lvl) && MII_10M == $past(spd_lvl))
    else $error("Strap levels not captured into MII bits");

  a_flow_ctrl_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    CFG_READY && !wr4 |=> CFG_READY && $stable(MII_FLOW_CTRL_EN))
    else $error("Flow control bit changed without a write");

  a_mii_write: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    wr4 |=> {MII_HALF_DUPLEX, MII_FLOW_CTRL_EN, MII_10M, NULL_VID_REPLACE} ==
            $past(REG_WDATA[6:3]))
    else $error("MII or null VID bits did not follow write");

  a_thr_low_write: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    wr5 && !wr4 |=> STORM_THRESHOLD[7:0] == $past(REG_WDATA) &&
                    $stable(STORM_THRESHOLD[10:8]))
    else $error("Threshold low byte write wrong");

  a_thr_default: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !CFG_READY |-> STORM_THRESHOLD == 11'h063 && !VLAN_EN && !NULL_VID_REPLACE)
    else $error("Threshold default not 0x063 before ready");

  a_tick_spacing: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    STORM_PERIOD_TICK |-> s_q.period_cnt == 24'h0 ##1 !STORM_PERIOD_TICK)
    else $error("Period ticks too close");

  a_readback: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    wr3 ##1 (REG_RD && !REG_WR && REG_ADDR == glob_cfg_pkg::VLAN_PRIORITY_SNIFF_CONTROL_OFS)
    |=> REG_RVALID && REG_RDATA == $past(REG_WDATA, 2))
    else $error("Read back of written byte wrong");

  c_strap_load: cover property (@(posedge REF_CLK) disable iff (!RST_B) $rose(CFG_READY));
  c_vlan_on: cover property (@(posedge REF_CLK) disable iff (!RST_B) $rose(VLAN_EN));
  c_period_tick: cover property (@(posedge REF_CLK) disable iff (!RST_B) STORM_PERIOD_TICK);
endmodule
`default_nettype wire

/* File: glob_cfg_pkg.sv */
`default_nettype none
package glob_cfg_pkg;
  // Register offsets
  localparam logic [7:0] VLAN_PRIORITY_SNIFF_CONTROL_OFS = 8'h05;
  localparam logic [7:0] MII_PORT_AND_STORM_HIGH_CONTROL_OFS = 8'h06;
  localparam logic [7:0] STORM_THRESHOLD_LOW_OFS = 8'h07;

  // Field positions, first register
  localparam int VLAN_EN_BIT = 7;
  localparam int PRIO_HI_BIT = 3;
  localparam int PRIO_LO_BIT = 2;
  localparam int SNIFF_AND_BIT = 0;
  // Field positions, second register
  localparam int MII_HALF_DUPLEX_BIT = 6;
  localparam int MII_FLOW_CTRL_BIT = 5;
  localparam int MII_10M_BIT = 4;
  localparam int NULL_VID_BIT = 3;
  localparam int STORM_HIGH_MSB = 2;

  // Reset values
  localparam logic [7:0] VLAN_PRIORITY_SNIFF_CONTROL_RST = 8'h00;
  localparam logic [7:0] MII_PORT_AND_STORM_HIGH_CONTROL_RST = 8'h00;
  localparam logic [7:0] STORM_THRESHOLD_LOW_RST = 8'h63;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  // High frames sent per low frame, by priority scheme
  localparam logic [3:0] RATIO_HIGH_FIRST = 4'h0;
  localparam logic [3:0] RATIO_10_TO_1 = 4'ha;
  localparam logic [3:0] RATIO_5_TO_1 = 4'h5;
  localparam logic [3:0] RATIO_2_TO_1 = 4'h2;

  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int STORM_PERIOD_10M_MS = 500;
  localparam int STORM_PERIOD_100M_MS = 67;
  localparam int STORM_PERIOD_10M_CYC = CLK_HZ / 1000 * STORM_PERIOD_10M_MS;
  localparam int STORM_PERIOD_100M_CYC = CLK_HZ / 1000 * STORM_PERIOD_100M_MS;
  localparam logic [2:0] STRAP_SETTLE_CYC = 3'h4;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } cfg_mode_t;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
  } sync_state_t;

  typedef struct packed {
    cfg_mode_t mode;
    logic [2:0] settle;
    logic [7:0] ctl3;
    logic [7:0] ctl4;
    logic [7:0] thr_low;
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] ratio;
    logic [23:0] period_cnt;
    logic tick;
  } cfg_state_t;
endpackage
`default_nettype wire

/* File: strap_sync.sv */
`default_nettype none
module strap_sync (
  input wire logic clk, // Core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic pin, // Asynchronous pin level
  output logic level // Filtered level
);
  glob_cfg_pkg::sync_state_t s_q;
  glob_cfg_pkg::sync_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.ff1 = pin;
    s_d.ff2 = s_q.ff1;
    s_d.ff3 = s_q.ff2;
    // Level changes only once two later stages agree
    if (s_q.ff2 == s_q.ff3) begin
      s_d.level = s_q.ff3;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;
endmodule
`default_nettype wire

/* File: switch_global_control_regs_tb.sv */
`default_nettype none
module switch_global_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P10 = 20;
  localparam int P100 = 8;
  logic ref_clk, rst_b, reg_wr, reg_rd, rvalid, cfg_ready, vlan_en, sniff_and;
  logic half_dup, flow_en, mii_10m, null_vid, tick;
  logic [7:0] reg_addr, reg_wdata, rdata, r5, r6, r7, d;
  logic [1:0] prio;
  logic [3:0] hpl;
  logic [10:0] thr;
  logic [2:0] straps;
  int mismatches = 0;
  int checked = 0;
  int n;
  switch_global_control_regs #(.STORM_PERIOD_10M_CYC(P10), .STORM_PERIOD_100M_CYC(P100))
  switch_global_control_regs_inst (
    .REF_CLK(ref_clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .MII_DUPLEX_STRAP_PIN(straps[2]), .MII_FLOW_CTRL_STRAP_PIN(straps[1]),
    .MII_SPEED_STRAP_PIN(straps[0]), .CFG_READY(cfg_ready), .VLAN_EN(vlan_en),
    .PRIO_SCHEME(prio), .HIGH_PER_LOW(hpl), .SNIFF_AND_MODE(sniff_and),
    .MII_HALF_DUPLEX(half_dup), .MII_FLOW_CTRL_EN(flow_en), .MII_10M(mii_10m),
    .NULL_VID_REPLACE(null_vid), .STORM_THRESHOLD(thr), .STORM_PERIOD_TICK(tick));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [3:0] ratio_of(input logic [1:0] s);
    case (s)
      2'h1: return 4'ha;
      2'h2: return 4'h5;
      2'h3: return 4'h2;
      default: return 4'h0;
    endcase
  endfunction
  task automatic report_and_stop();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk);
    #1 reg_rd = 1'b0;
    chk(11'(rvalid), 11'h1);
    chk(11'(rdata), 11'(exp));
    @(posedge ref_clk);
    #1 chk(11'(rvalid), 11'h0);
  endtask
  // Write, then read the same address on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1 reg_rd = 1'b0;
    chk(11'(rvalid), 11'h1);
    chk(11'(rdata), 11'(v));
  endtask
  // Outputs against the shadow copies of all three registers
  task automatic chk_fields();
    chk(11'(vlan_en), 11'(r5[7]));
    chk(11'(prio), 11'(r5[3:2]));
    chk(11'(hpl), 11'(ratio_of(r5[3:2])));
    chk(11'(sniff_and), 11'(r5[0]));
    chk(11'(half_dup), 11'(r6[6]));
    chk(11'(flow_en), 11'(r6[5]));
    chk(11'(mii_10m), 11'(r6[4]));
    chk(11'(null_vid), 11'(r6[3]));
    chk(thr, {r6[2:0], r7});
  endtask
  task automatic wr_all(input logic [7:0] a5, input logic [7:0] a6, input logic [7:0] a7);
    r5 = a5;
    r6 = a6;
    r7 = a7;
    wr_rd(8'h05, a5);
    wr(8'h06, a6);
    wr(8'h07, a7);
    chk_fields();
    rd(8'h05, r5);
    rd(8'h06, r6);
    rd(8'h07, r7);
  endtask
  // Cycles between two period ticks at the current speed
  task automatic tick_gap(input int exp);
    n = 0;
    while (tick !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= 60) begin
      mismatches++;
      report_and_stop();
    end
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (tick !== 1'b1 && n < 60);
    chk(11'(n), 11'(exp));
    if (n >= 60) report_and_stop();
  endtask
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    d = 8'($urandom(32'hcf15));
    straps = 3'($urandom);
    repeat (20) @(posedge ref_clk);
    #1 chk(thr, 11'h063);
    chk(11'(cfg_ready), 11'h0);
    rst_b = 1'b1;
    wr(8'h05, 8'hff);
    n = 0;
    while (cfg_ready !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= 20) begin
      mismatches++;
      report_and_stop();
    end
    r5 = 8'h00;
    r6 = {1'b0, straps, 4'h0};
    r7 = 8'h63;
    chk_fields();
    rd(8'h05, 8'h00);
    rd(8'h06, r6);
    rd(8'h07, 8'h63);
    for (int s = 0; s < 4; s++) begin
      wr_all({1'b1, 3'h0, 2'(s), 1'b0, 1'(s)}, 8'h07, 8'hff);
    end
    wr(8'h08, 8'h5a);
    chk_fields();
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr_all(8'($urandom), 8'($urandom), 8'($urandom));
    end
    wr_all(d, {4'h0, 4'h8}, 8'h00);
    tick_gap(P100);
    tick_gap(P100);
    wr_all(d, 8'h10, 8'h63);
    tick_gap(P10);
    tick_gap(P10);
    report_and_stop();
  end
endmodule
`default_nettype wire
